// ---- verilog/oiac_output_control.sv ----
// Purpose: interleave, half-band routing and gain-loop sync control for ports A and B
// Assumes: channel data and sync pin synchronous to clk_sys_i
// Notes: gain arithmetic lives downstream; this block paces and formats it
`timescale 1ns/10ps
`include "oiac_params.svh"
module oiac_output_control import oiac_pkg::*; (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    input wire logic [3:0][15:0] ch_data_i,
    input wire logic pin_sync_i,
    output oiac_word_t port_a_o,
    output oiac_word_t port_b_o,
    output logic agc_update_o,
    output logic agc_init_o,
    output logic [23:0] agc_level_o,
    output logic agc_mode_clip_o,
    output logic [4:0] word_len_o,
    output logic [14:0] target_mdb_o
);
    function automatic logic [4:0] wl_bits(input logic [2:0] code);
        case (code)
            3'h7: wl_bits = 5'h04;
            3'h6: wl_bits = 5'h05;
            3'h5: wl_bits = 5'h06;
            3'h4: wl_bits = 5'h07;
            3'h3: wl_bits = 5'h08;
            3'h2: wl_bits = 5'h0a;
            3'h1: wl_bits = 5'h0c;
            default: wl_bits = 5'h10;
        endcase
    endfunction

    function automatic logic [15:0] wl_mask(input logic [2:0] code);
        wl_mask = 16'hffff << (5'h10 - wl_bits(code));
    endfunction

    logic [3:0] hb_a_ctl;
    logic [2:0] hb_b_ctl;
    logic [7:0] gl_ctl;
    logic [15:0] hold_val;
    logic [7:0] level;
    logic [1:0] idx_a;
    logic idx_b;
    logic pin_q;
    logic seen;
    logic [15:0] hold_cnt;
    logic hold_init;
    oiac_sync_t state;
    logic [11:0] dec_cnt;
    logic [23:0] cic_acc;

    // Register decode
    wire wr_hb_a = reg_wr_i && reg_addr_i == `OIAC_ADDR_HB_A;
    wire wr_hb_b = reg_wr_i && reg_addr_i == `OIAC_ADDR_HB_B;
    wire wr_gl = reg_wr_i && reg_addr_i == `OIAC_ADDR_GL_CTL;
    wire wr_hold = reg_wr_i && reg_addr_i == `OIAC_ADDR_GL_HOLD;
    wire wr_level = reg_wr_i && reg_addr_i == `OIAC_ADDR_GL_LEVEL;
    logic [15:0] rd_mux;
    always_comb begin
        if (reg_addr_i == `OIAC_ADDR_HB_A) begin
            rd_mux = {12'h000, hb_a_ctl};
        end else if (reg_addr_i == `OIAC_ADDR_HB_B) begin
            rd_mux = {13'h0000, hb_b_ctl};
        end else if (reg_addr_i == `OIAC_ADDR_GL_CTL) begin
            rd_mux = {8'h00, gl_ctl};
        end else if (reg_addr_i == `OIAC_ADDR_GL_HOLD) begin
            rd_mux = hold_val;
        end else if (reg_addr_i == `OIAC_ADDR_GL_LEVEL) begin
            rd_mux = {8'h00, level};
        end else begin
            rd_mux = 16'h0000;
        end
    end

    // Sync-now is a pulse, never stored
    wire sync_now = wr_gl && reg_wdata_i[`OIAC_GL_SYNC_NOW];
    wire init_sel = wr_gl ? reg_wdata_i[`OIAC_GL_INIT] : gl_ctl[`OIAC_GL_INIT];
    wire first_only = gl_ctl[`OIAC_GL_FIRST_ONLY];

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            hb_a_ctl <= `OIAC_RST_HB_A;
            hb_b_ctl <= `OIAC_RST_HB_B;
            gl_ctl <= `OIAC_RST_GL_CTL;
            hold_val <= `OIAC_RST_GL_HOLD;
            level <= `OIAC_RST_GL_LEVEL;
            reg_rdata_o <= 16'h0000;
        end else begin
            if (wr_hb_a) begin
                hb_a_ctl <= reg_wdata_i[3:0];
            end
            if (wr_hb_b) begin
                hb_b_ctl <= reg_wdata_i[2:0];
            end
            if (wr_gl) begin
                gl_ctl <= reg_wdata_i[7:0] & 8'hf7;
            end
            if (wr_hold) begin
                hold_val <= reg_wdata_i;
            end
            if (wr_level) begin
                level <= reg_wdata_i[7:0];
            end
            if (reg_rd_i) begin
                reg_rdata_o <= rd_mux;
            end
        end
    end

    // Port A interleaver
    wire ena_a = hb_a_ctl[`OIAC_HBA_ENABLE];
    wire [1:0] last_a = hb_a_ctl[2:1];
    logic hb_a_ready;
    oiac_word_t iv_a;
    assign iv_a = '{ena_a & hb_a_ready, idx_a, ch_data_i[idx_a]};

    // Port B interleaver, channels 2 and 3 only
    wire ena_b = hb_b_ctl[`OIAC_HBB_ENABLE];
    wire sel_b = hb_b_ctl[`OIAC_HB_SEL_LO];
    logic hb_b_ready;
    oiac_word_t iv_b;
    assign iv_b = '{ena_b & hb_b_ready, {1'b1, idx_b}, ch_data_i[{1'b1, idx_b}]};

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            idx_a <= 2'h0;
            idx_b <= 1'b0;
        end else begin
            if (!ena_a || (iv_a.valid && idx_a >= last_a)) begin
                idx_a <= 2'h0;
            end else if (iv_a.valid) begin
                idx_a <= idx_a + 2'h1;
            end
            if (!ena_b || (iv_b.valid && (idx_b || !sel_b))) begin
                idx_b <= 1'b0;
            end else if (iv_b.valid) begin
                idx_b <= 1'b1;
            end
        end
    end

    oiac_word_t hb_a_out;
    oiac_word_t hb_b_out;
    oiac_halfband u_hb_a (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .bypass_i(hb_a_ctl[`OIAC_HB_BYPASS]),
        .in_i(iv_a),
        .ready_o(hb_a_ready),
        .out_o(hb_a_out)
    );
    oiac_halfband u_hb_b (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .bypass_i(hb_b_ctl[`OIAC_HB_BYPASS]),
        .in_i(iv_b),
        .ready_o(hb_b_ready),
        .out_o(hb_b_out)
    );

    // Gain stage: bypass or not, port A output is cut to the chosen width; port B passes uncut
    wire [2:0] wl_code = gl_ctl[7:5];
    wire [15:0] trunc_a = hb_a_out.data & wl_mask(wl_code);
    wire [15:0] abs_a = hb_a_out.data[15] ? 16'(~hb_a_out.data + 16'h0001) : hb_a_out.data;

    // Sync handling for the gain-loop decimator
    wire pin_rise = pin_sync_i && !pin_q;
    wire pin_take = pin_rise && hold_val != 16'h0000 && !(first_only && seen);
    wire hold_done = state == SY_HOLD && hold_cnt == 16'h0001 && !pin_take;
    wire start_upd = sync_now || hold_done;
    wire start_init = sync_now ? init_sel : hold_init;
    wire dec_end = hb_a_out.valid && dec_cnt == `OIAC_DEC_RATIO - 12'h001;
    wire [14:0] next_target = 15'(level[7:6] * `OIAC_EXP_MDB) + 15'(level[5:0] * `OIAC_MANT_MDB);

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            pin_q <= 1'b0;
            seen <= 1'b0;
            state <= SY_IDLE;
            hold_cnt <= 16'h0000;
            hold_init <= 1'b0;
        end else begin
            pin_q <= pin_sync_i;
            seen <= pin_take | (seen & first_only);
            case (state)
                SY_IDLE: begin
                    if (pin_take) begin
                        state <= SY_HOLD;
                        hold_cnt <= hold_val;
                        hold_init <= gl_ctl[`OIAC_GL_INIT];
                    end
                end
                SY_HOLD: begin
                    if (sync_now) begin
                        state <= SY_IDLE;
                    end else if (pin_take) begin
                        hold_cnt <= hold_val;
                        hold_init <= gl_ctl[`OIAC_GL_INIT];
                    end else if (hold_cnt == 16'h0001) begin
                        state <= SY_IDLE;
                        hold_cnt <= 16'h0000;
                    end else begin
                        hold_cnt <= hold_cnt - 16'h0001;
                    end
                end
                default: state <= SY_IDLE;
            endcase
        end
    end

    // Update decimator and outputs
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            dec_cnt <= 12'h000;
            cic_acc <= 24'h000000;
            agc_update_o <= 1'b0;
            agc_init_o <= 1'b0;
            agc_level_o <= 24'h000000;
            port_a_o <= '0;
            port_b_o <= '0;
            agc_mode_clip_o <= 1'b0;
            word_len_o <= 5'h10;
            target_mdb_o <= 15'h0000;
        end else begin
            agc_update_o <= start_upd || dec_end;
            agc_init_o <= start_upd && start_init;
            if (start_upd || dec_end) begin
                agc_level_o <= cic_acc;
                dec_cnt <= 12'h000;
            end else if (hb_a_out.valid) begin
                dec_cnt <= dec_cnt + 12'h001;
            end
            if (start_upd && start_init) begin
                cic_acc <= 24'h000000;
            end else if (dec_end) begin
                cic_acc <= {8'h00, abs_a};
            end else if (hb_a_out.valid && !start_upd) begin
                cic_acc <= cic_acc + {8'h00, abs_a};
            end else if (start_upd) begin
                cic_acc <= 24'h000000;
            end
            port_a_o <= '{hb_a_out.valid, hb_a_out.chan, trunc_a};
            port_b_o <= hb_b_out;
            agc_mode_clip_o <= gl_ctl[`OIAC_GL_MODE];
            word_len_o <= wl_bits(wl_code);
            target_mdb_o <= next_target;
        end
    end

    a_port_a_quiet: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (!ena_a)[*4] |-> !port_a_o.valid)
        else $error("port A data while disabled");
    a_chan_a_range: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        iv_a.valid |-> iv_a.chan <= last_a)
        else $error("port A channel outside select");
    a_chan_b_set: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        iv_b.valid && !sel_b && $stable(hb_b_ctl) |-> iv_b.chan == 2'h2)
        else $error("port B used channel 3 with select clear");
    a_sync_now_upd: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        sync_now |=> agc_update_o && agc_init_o == $past(init_sel) && gl_ctl[3] == 1'b0)
        else $error("sync now gave no update");
    a_hold_load: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        pin_take && !sync_now |=> state == SY_HOLD && hold_cnt == $past(hold_val))
        else $error("hold-off not loaded");
    a_hold_zero: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        state == SY_IDLE && hold_val == 16'h0000 && !sync_now |=> state == SY_IDLE && !agc_init_o)
        else $error("sync taken with zero hold-off");
    a_hold_end: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        state == SY_HOLD && hold_cnt == 16'h0002 && !pin_take && !sync_now ##1 !pin_take && !sync_now
        |=> agc_update_o && state == SY_IDLE)
        else $error("hold-off expiry gave no update");
    a_first_only: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        first_only && seen && pin_rise && state == SY_IDLE && !sync_now |=> state == SY_IDLE)
        else $error("second sync honoured in first-only mode");
    a_trunc_width: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        port_a_o.valid && $stable(wl_code) |-> (port_a_o.data & ~wl_mask(wl_code)) == 16'h0000)
        else $error("port A word wider than selected");
    a_target_code: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        $stable(level) |-> target_mdb_o == 15'(level[7:6] * 15'd6020) + 15'(level[5:0] * 15'd94))
        else $error("target level decode wrong");
endmodule

// ---- verilog/oiac_params.svh ----
// Purpose: constants of the output interleave and gain-loop control block
// Assumes: 8-bit register address, 16-bit register data
// Notes: offsets, field positions, reset values and fixed counts
// Summary of operation
// - Port A enable low stops the interleaver; nothing reaches half-band or gain stage.
// - Port A enabled interleaves up to four channels picked by select field.
// - Select 11 gives ch0-3, 10 ch0-2, 01 ch0-1, 00 ch0 only.
// - Half-band bypass high sends interleaved data straight on, no interpolation.
// - Bypass low filters through half-band with 2x interpolation.
// - Port B works as A: two channels, bit 1 selects, bit 2 enables.
// - Port B select set gives channels 2 and 3; clear gives channel 2.
// - Gain output width is chosen by a three-bit field.
// - Width codes 111..000 give 4,5,6,7,8,10,12,16 bits.
// - Mode bit 0 tracks output level; 1 tracks clipping error.
// - Update decimator syncs to an external signal and emits an update sample.
// - Every rising of the sync pin retriggers the hold-off one-shot, except with hold-off zero, a later event in first-sync-only mode or a sync-now in hold-off.
// - Sync-now starts a new update at once, skips hold-off, may initialise.
// - Sync-now self-clears so each write of one retriggers.
// - Init-on-sync set: sync clears decimator and loads fresh loop parameters.
// - Init-on-sync clear: state kept; update sample still emitted and restarted.
// - First-sync-only set honours only the first pin event until cleared.
// - Gain bypass skips gain but still truncates to the chosen width; the bypass bit is only stored and drives no output here; port B is not cut.
// - Pin event loads hold-off counter with programmed value; sync-now cancels a running hold-off.
// - Hold-off value zero means the loop is not synchronised.
// - Target level means output power or clipping level per mode.
// - Target level is 2-bit exponent of 6.02 dB and 6-bit mantissa of 0.094 dB.
`ifndef OIAC_PARAMS_SVH
`define OIAC_PARAMS_SVH
`define OIAC_ADDR_HB_A 8'h08
`define OIAC_ADDR_HB_B 8'h09
`define OIAC_ADDR_GL_CTL 8'h0a
`define OIAC_ADDR_GL_HOLD 8'h0b
`define OIAC_ADDR_GL_LEVEL 8'h0c
`define OIAC_HB_BYPASS 0
`define OIAC_HB_SEL_LO 1
`define OIAC_HBA_ENABLE 3
`define OIAC_HBB_ENABLE 2
`define OIAC_GL_BYPASS 0
`define OIAC_GL_FIRST_ONLY 1
`define OIAC_GL_INIT 2
`define OIAC_GL_SYNC_NOW 3
`define OIAC_GL_MODE 4
`define OIAC_GL_WL_LO 5
`define OIAC_RST_HB_A 4'h0
`define OIAC_RST_HB_B 3'h0
`define OIAC_RST_GL_CTL 8'h00
`define OIAC_RST_GL_HOLD 16'h0000
`define OIAC_RST_GL_LEVEL 8'h00
`define OIAC_EXP_MDB 15'h1784
`define OIAC_MANT_MDB 15'h005e
`define OIAC_DEC_RATIO 12'h010
`endif

// ---- verilog/oiac_pkg.sv ----
// Purpose: shared types of the output interleave and gain-loop control block
// Assumes: four downconverter channels of 16-bit data
// Notes: word carries its channel tag
package oiac_pkg;
    typedef struct packed {
        logic valid;
        logic [1:0] chan;
        logic [15:0] data;
    } oiac_word_t;
    typedef enum logic [1:0] {
        SY_IDLE = 2'b01,
        SY_HOLD = 2'b10
    } oiac_sync_t;
endpackage

// ---- verilog/oiac_halfband.sv ----
// Purpose: 2x interpolating stage on an interleaved, channel-tagged stream
// Assumes: input is taken only while ready_o is high
// Notes: per channel history keeps interleaved streams apart
`timescale 1ns/10ps
module oiac_halfband import oiac_pkg::*; (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic bypass_i,
    input wire oiac_word_t in_i,
    output logic ready_o,
    output oiac_word_t out_o
);
    logic [3:0][15:0] prev;
    logic phase;
    oiac_word_t held;
    wire [15:0] last_w = prev[in_i.chan];
    wire [16:0] sum_w = {last_w[15], last_w} + {in_i.data[15], in_i.data};

    // Second half of a pair blocks new input
    assign ready_o = bypass_i | ~phase;

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            out_o <= '0;
            held <= '0;
            prev <= '0;
            phase <= 1'b0;
        end else if (bypass_i) begin
            out_o <= in_i;
            phase <= 1'b0;
        end else if (phase) begin
            out_o <= held;
            phase <= 1'b0;
        end else if (in_i.valid) begin
            out_o <= '{1'b1, in_i.chan, sum_w[16:1]};
            held <= in_i;
            prev[in_i.chan] <= in_i.data;
            phase <= 1'b1;
        end else begin
            out_o <= '0;
        end
    end
endmodule

// ---- test/oiac_chan_model.sv ----
// Purpose: stand-in for the four downconverter channels and their sync pin
// Assumes: one clock shared with the block under test
// Notes: sync pin is the channel 0 pin; samples step every cycle
`timescale 1ns/10ps
module oiac_chan_model (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic sync_req_i,
    output logic [3:0][15:0] ch_data_o,
    output logic pin_sync_o
);
    logic [1:0] high_left;
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            high_left <= 2'h0;
            pin_sync_o <= 1'b0;
            ch_data_o <= '0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                ch_data_o[i] <= ch_data_o[i] + 16'h1357 + 16'(i);
            end
            if (sync_req_i) begin
                high_left <= 2'h1;
                pin_sync_o <= 1'b1;
            end else if (high_left != 2'h0) begin
                high_left <= high_left - 2'h1;
            end else begin
                pin_sync_o <= 1'b0;
            end
        end
    end
endmodule

// ---- test/tb.sv ----
// Purpose: self-checking bench of the output interleave and gain-loop control block
// Assumes: 10 MHz clock, reset held 16 cycles, fixed seed
// Notes: port A kept off during sync checks so decimator updates stay quiet
`timescale 1ns/10ps
`include "oiac_params.svh"
module tb import oiac_pkg::*;;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic sync_req = 1'b0;
    logic pin_q = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic [15:0] reg_rdata_o;
    logic [3:0][15:0] ch_data_i;
    logic pin_sync_i;
    oiac_word_t port_a_o;
    oiac_word_t port_b_o;
    logic agc_update_o;
    logic agc_init_o;
    logic agc_mode_clip_o;
    logic [23:0] agc_level_o;
    logic [4:0] word_len_o;
    logic [14:0] target_mdb_o;
    logic [23:0] since = 24'h0;
    int n_errors = 0;
    int comparisons = 0;
    logic [4:0] wl_tab [8] = '{5'h10, 5'h0c, 5'h0a, 5'h08, 5'h07, 5'h06, 5'h05, 5'h04};
    logic [7:0] ra [5] = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c};
    logic [15:0] rm [5] = '{16'h000f, 16'h0007, 16'h00f7, 16'hffff, 16'h00ff};

    oiac_output_control u_oiac_output_control (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .ch_data_i(ch_data_i), .pin_sync_i(pin_sync_i), .port_a_o(port_a_o),
        .port_b_o(port_b_o), .agc_update_o(agc_update_o), .agc_init_o(agc_init_o),
        .agc_level_o(agc_level_o), .agc_mode_clip_o(agc_mode_clip_o), .word_len_o(word_len_o),
        .target_mdb_o(target_mdb_o));
    oiac_chan_model u_oiac_chan_model (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .sync_req_i(sync_req),
        .ch_data_o(ch_data_i), .pin_sync_o(pin_sync_i));

    initial begin
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    // Cycles since the pin was last seen rising
    always @(posedge clk_sys_i) begin
        pin_q <= pin_sync_i;
        since <= (pin_sync_i && !pin_q) ? 24'h0 : since + 24'h1;
    end

    function automatic logic [23:0] exp_mdb(input logic [7:0] lvl);
        return 24'(lvl[7:6] * 6020 + lvl[5:0] * 94);
    endfunction
    // Magnitude of a signed sample as the decimator sums it
    function automatic logic [23:0] mag(input logic [15:0] v);
        return v[15] ? 24'h010000 - 24'(v) : 24'(v);
    endfunction
    task automatic give_verdict();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        @(posedge clk_sys_i);
        #1 d = reg_rdata_o;
    endtask
    task automatic pulse();
        @(posedge clk_sys_i);
        sync_req <= 1'b1;
        @(posedge clk_sys_i);
        sync_req <= 1'b0;
    endtask
    task automatic wait_upd(input int lim, output logic got);
        got = 1'b0;
        for (int i = 0; i < lim && !got; i++) begin
            @(posedge clk_sys_i);
            #1 got = agc_update_o;
        end
    endtask
    task automatic stream(input logic b, input logic [1:0] sel, input logic byp, input logic [2:0] wl);
        oiac_word_t w;
        int k;
        int n;
        logic [7:0] a;
        logic [15:0] lowmask;
        logic [3:0][15:0] h1;
        logic [3:0][15:0] h2;
        k = 0;
        n = b ? sel[0] + 1 : sel + 1;
        a = b ? `OIAC_ADDR_HB_B : `OIAC_ADDR_HB_A;
        lowmask = 16'hffff >> wl_tab[wl];
        wr(`OIAC_ADDR_GL_CTL, {8'h00, wl, 5'h01});
        wr(a, b ? {13'h0, 1'b1, sel[0], byp} : {12'h0, 1'b1, sel, byp});
        #1 h1 = ch_data_i;
        repeat (40) begin
            @(posedge clk_sys_i);
            #1 w = b ? port_b_o : port_a_o;
            if (w.valid === 1'b1) begin
                chk("chan", 24'((b ? 2 : 0) + (byp ? k : k / 2) % n), 24'(w.chan));
                if (!b) chk("low bits", 24'h0, 24'(w.data & lowmask));
                if (byp) chk("data", 24'(h2[w.chan] & ~(b ? 16'h0000 : lowmask)), 24'(w.data));
                k++;
            end
            h2 = h1;
            h1 = ch_data_i;
        end
        chk("words seen", 24'h1, 24'(k > 8));
        wr(a, 16'h0000);
        repeat (3) @(posedge clk_sys_i);
        k = 0;
        repeat (20) begin
            @(posedge clk_sys_i);
            #1 w = b ? port_b_o : port_a_o;
            if (w.valid !== 1'b0) k++;
        end
        chk("idle words", 24'h0, 24'(k));
    endtask

    initial begin
        #(100 * 90000);
        n_errors++;
        give_verdict();
    end
    initial begin
        logic [15:0] d;
        logic [7:0] lvl;
        logic got;
        int n;
        int nw;
        logic [23:0] acc;
        logic [23:0] win [16];
        n = $urandom(65604);
        repeat (16) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        #1 chk("reset word len", 24'h10, 24'(word_len_o));
        for (int i = 0; i < 5; i++) begin
            rd(ra[i], d);
            chk("reset value", 24'h0, 24'(d));
            n = $urandom;
            wr(ra[i], 16'(n));
            rd(ra[i], d);
            chk("readback", 24'(16'(n) & rm[i]), 24'(d));
            wr(ra[i], 16'h0000);
        end
        wr(8'h20, 16'hffff);
        rd(8'h20, d);
        chk("unmapped", 24'h0, 24'(d));
        for (int c = 0; c < 8; c++) begin
            lvl = 8'($urandom);
            wr(`OIAC_ADDR_GL_CTL, {8'h00, 3'(c), c[0], 4'h0});
            wr(`OIAC_ADDR_GL_LEVEL, {8'h00, lvl});
            repeat (2) @(posedge clk_sys_i);
            #1 chk("word len", 24'(wl_tab[c]), 24'(word_len_o));
            chk("mode", 24'(c[0]), 24'(agc_mode_clip_o));
            chk("target", exp_mdb(lvl), 24'(target_mdb_o));
        end
        for (int i = 0; i < 12; i++) stream(i >= 8, 2'(i >> 1), i[0], 3'($urandom));
        // Decimator level: sum of the 16 port A words before the update word
        acc = 24'h0;
        nw = 0;
        for (int j = 0; j < 16; j++) win[j] = 24'h0;
        wr(`OIAC_ADDR_GL_CTL, 16'h0001);
        wr(`OIAC_ADDR_HB_A, 16'h0009);
        for (int i = 0; i < 80; i++) begin
            @(posedge clk_sys_i);
            #1;
            if (agc_update_o && nw >= 16) chk("level", acc, agc_level_o);
            if (port_a_o.valid) begin
                acc = acc + mag(port_a_o.data) - win[15];
                for (int j = 15; j > 0; j--) win[j] = win[j - 1];
                win[0] = mag(port_a_o.data);
                nw++;
            end
        end
        wr(`OIAC_ADDR_HB_A, 16'h0000);
        repeat (4) @(posedge clk_sys_i);
        n = 10 + $urandom_range(30);
        wr(`OIAC_ADDR_GL_HOLD, 16'(n));
        wr(`OIAC_ADDR_GL_CTL, 16'h0004);
        pulse();
        wait_upd(300, got);
        chk("pin delay", 24'(n), since);
        chk("pin init", 24'h1, 24'(agc_init_o));
        wr(`OIAC_ADDR_GL_CTL, 16'h0000);
        pulse();
        repeat (5) @(posedge clk_sys_i);
        pulse();
        wait_upd(300, got);
        chk("retrigger delay", 24'(n), since);
        chk("no init", 24'h0, 24'(agc_init_o));
        wr(`OIAC_ADDR_GL_CTL, 16'h0002);
        pulse();
        wait_upd(300, got);
        chk("first event", 24'h1, 24'(got));
        pulse();
        wait_upd(n + 20, got);
        chk("later event", 24'h0, 24'(got));
        wr(`OIAC_ADDR_GL_CTL, 16'h0000);
        pulse();
        wait_upd(300, got);
        chk("event after clear", 24'h1, 24'(got));
        wr(`OIAC_ADDR_GL_HOLD, 16'h0000);
        pulse();
        wait_upd(60, got);
        chk("hold zero", 24'h0, 24'(got));
        wr(`OIAC_ADDR_GL_HOLD, 16'(n));
        pulse();
        repeat (4) @(posedge clk_sys_i);
        wr(`OIAC_ADDR_GL_CTL, 16'h000c);
        #1 chk("sync now", 24'h3, {22'h0, agc_update_o, agc_init_o});
        wr(`OIAC_ADDR_GL_CTL, 16'h0008);
        #1 chk("sync now again", 24'h2, {22'h0, agc_update_o, agc_init_o});
        wait_upd(n + 20, got);
        chk("hold cancelled", 24'h0, 24'(got));
        give_verdict();
    end
endmodule
